//--- include/pec_pkg.sv
// Package for the pulse edge counter: timing constants, variants and widths
package pec_pkg;
   // Module variant selection
   typedef enum logic
   {
      PEC_VARIANT_EDGE,
      PEC_VARIANT_STAMP
   } pec_variant_t;

   localparam int PEC_COUNT_W = 32;
   localparam int PEC_STAMP_W = 32;
   localparam int PEC_OPTION_W = 16;
   localparam logic [PEC_OPTION_W-1:0] PEC_OPTION_TOTAL = 16'h0000;

   // Timestamp tick period and derived clock count
   localparam int PEC_CLK_PERIOD_NS = 4;
   localparam int PEC_STAMP_TICK_NS = 40;
   localparam int PEC_STAMP_DIV = (PEC_STAMP_TICK_NS + PEC_CLK_PERIOD_NS - 1) / PEC_CLK_PERIOD_NS;
   localparam int PEC_DIV_W = 4;
   localparam logic [PEC_DIV_W-1:0] PEC_DIV_LAST = PEC_DIV_W'(PEC_STAMP_DIV - 1);
   localparam logic [PEC_DIV_W-1:0] PEC_DIV_ZERO = 4'h0;

   localparam logic [PEC_COUNT_W-1:0] PEC_COUNT_ZERO = 32'h00000000;
   localparam logic [PEC_COUNT_W-1:0] PEC_COUNT_ONE = 32'h00000001;
   localparam logic [PEC_STAMP_W-1:0] PEC_STAMP_ZERO = 32'h00000000;
   localparam logic [PEC_STAMP_W-1:0] PEC_STAMP_ONE = 32'h00000001;
endpackage : pec_pkg

//--- rtl/pec_stamp_timer.sv
// Free-running 40 ns timestamp counter
`timescale 1ns/100ps
module pec_stamp_timer
   import pec_pkg::*;
(
   input wire logic core_clk_i,
   input wire logic rst_i,
   output logic [PEC_STAMP_W-1:0] stamp_o
);

   logic [PEC_DIV_W-1:0] div_cnt;
   wire tick = (div_cnt == PEC_DIV_LAST);
   wire [PEC_DIV_W-1:0] next_div_cnt = tick ? PEC_DIV_ZERO : div_cnt + PEC_DIV_W'(1);
   // Wraps modulo 2^32, the host takes the unsigned difference
   wire [PEC_STAMP_W-1:0] next_stamp = stamp_o + PEC_STAMP_ONE; // [R16]

   always_ff @(posedge core_clk_i)
   begin
      if (rst_i)
      begin
         div_cnt <= PEC_DIV_ZERO;
         stamp_o <= PEC_STAMP_ZERO;
      end
      else
      begin
         div_cnt <= next_div_cnt;
         if (tick)
         begin
            stamp_o <= next_stamp; // [R12]
         end
      end
   end

   AST_STAMP_STEP: assert property (@(posedge core_clk_i) disable iff (rst_i)
      $past(tick) && !$past(rst_i) |-> stamp_o == $past(stamp_o) + PEC_STAMP_ONE) // [R12]
      else $error("Timestamp did not advance on tick");

   AST_STAMP_HOLD: assert property (@(posedge core_clk_i) disable iff (rst_i)
      !$past(tick) && !$past(rst_i) |-> $stable(stamp_o)) // [R12]
      else $error("Timestamp moved between ticks");

endmodule : pec_stamp_timer

//--- rtl/pec_counter.sv
// Pulse edge counter with per-scan snapshot and edge timestamp capture
`timescale 1ns/100ps

// How it works
// R01 - Option zero: report raw running total, never cleared per scan.
// R02 - Edge variant counts rising edges; stamp variant counts falling edges.
// R03 - Every qualifying edge adds exactly one to the count.
// R04 - Host divides counts by scan interval for frequency.
// R05 - Host treats option above one as running-average window in ms.
// R06 - Host reports scan frequency on edge scans, zero otherwise.
// R07 - Host averaged edge-count output holds or decays to zero.
// R08 - Host keeps over-range value in average for full window.
// R09 - On scan tick the count is snapshotted and counter cleared.
// R10 - Stamp variant supplies last edge time before and within previous scan.
// R11 - Host computes period from stamps at 40 ns and divides count.
// R12 - Timestamps come from a 32-bit counter ticking every 40 ns.
// R13 - Host reports true frequency on edge scans, zero otherwise.
// R14 - Host averaged stamp output holds true value or drops to zero.
// R15 - Host should provision at least 500 scan buffers.
// R16 - Timestamp counter wraps freely; host uses unsigned difference.
module pec_counter
   import pec_pkg::*;
(
   input wire logic core_clk_i,
   input wire logic rst_i,
   input wire logic pulse_i,
   input wire logic scan_tick_i,
   input wire logic variant_i,
   input wire logic [PEC_OPTION_W-1:0] averaging_option_i,
   output logic [PEC_COUNT_W-1:0] edge_tally_instruction_o,
   output logic [PEC_STAMP_W-1:0] stamp_before_o,
   output logic [PEC_STAMP_W-1:0] stamp_within_o,
   output logic result_valid_o
);

   // ----------------------------------------------------------------
   // Input synchroniser and edge detect
   // ----------------------------------------------------------------
   logic pulse_meta;
   logic pulse_sync;
   logic pulse_prev;

   always_ff @(posedge core_clk_i)
   begin
      if (rst_i)
      begin
         pulse_meta <= 1'b0;
         pulse_sync <= 1'b0;
         pulse_prev <= 1'b0;
      end
      else
      begin
         pulse_meta <= pulse_i;
         pulse_sync <= pulse_meta;
         pulse_prev <= pulse_sync;
      end
   end

   wire rise_seen = pulse_sync && !pulse_prev;
   wire fall_seen = !pulse_sync && pulse_prev;
   wire stamp_mode = (pec_variant_t'(variant_i) == PEC_VARIANT_STAMP);
   wire edge_hit = stamp_mode ? fall_seen : rise_seen; // [R02]
   wire total_mode = (averaging_option_i == PEC_OPTION_TOTAL);

   // ----------------------------------------------------------------
   // Timestamp source
   // ----------------------------------------------------------------
   logic [PEC_STAMP_W-1:0] stamp_now;

   pec_stamp_timer u_timer
   (
      .core_clk_i(core_clk_i),
      .rst_i(rst_i),
      .stamp_o(stamp_now)
   );

   // ----------------------------------------------------------------
   // Accumulator and capture
   // ----------------------------------------------------------------
   logic [PEC_COUNT_W-1:0] accum;
   logic [PEC_STAMP_W-1:0] last_edge_stamp;
   logic [PEC_STAMP_W-1:0] prev_scan_stamp;

   // Outside total mode an edge landing on the scan tick belongs to the new interval, so it is not lost
   wire [PEC_COUNT_W-1:0] accum_inc = accum + PEC_COUNT_ONE; // [R03]
   wire [PEC_COUNT_W-1:0] accum_base = (scan_tick_i && !total_mode) ? PEC_COUNT_ZERO : accum; // [R09]
   wire [PEC_COUNT_W-1:0] accum_base_inc = accum_base + PEC_COUNT_ONE;
   wire [PEC_COUNT_W-1:0] next_accum = edge_hit ? accum_base_inc : accum_base;
   // Snapshot includes a same-cycle edge in total mode only, so the total stays exact
   wire [PEC_COUNT_W-1:0] next_report = (total_mode && edge_hit) ? accum_inc : accum; // [R01]
   wire [PEC_STAMP_W-1:0] next_last_edge = edge_hit ? stamp_now : last_edge_stamp;

   always_ff @(posedge core_clk_i)
   begin
      if (rst_i)
      begin
         accum <= PEC_COUNT_ZERO;
         last_edge_stamp <= PEC_STAMP_ZERO;
         prev_scan_stamp <= PEC_STAMP_ZERO;
      end
      else
      begin
         accum <= next_accum; // [R03]
         last_edge_stamp <= next_last_edge;
         if (scan_tick_i)
         begin
            prev_scan_stamp <= last_edge_stamp;
         end
      end
   end

   // ----------------------------------------------------------------
   // Scan outputs
   // ----------------------------------------------------------------
   wire [PEC_STAMP_W-1:0] next_before = stamp_mode ? prev_scan_stamp : PEC_STAMP_ZERO;
   wire [PEC_STAMP_W-1:0] next_within = stamp_mode ? last_edge_stamp : PEC_STAMP_ZERO;

   always_ff @(posedge core_clk_i)
   begin
      if (rst_i)
      begin
         edge_tally_instruction_o <= PEC_COUNT_ZERO;
         stamp_before_o <= PEC_STAMP_ZERO;
         stamp_within_o <= PEC_STAMP_ZERO;
         result_valid_o <= 1'b0;
      end
      else
      begin
         result_valid_o <= scan_tick_i;
         if (scan_tick_i)
         begin
            edge_tally_instruction_o <= next_report; // [R09]
            stamp_before_o <= next_before; // [R10]
            stamp_within_o <= next_within; // [R10]
         end
      end
   end

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   AST_COUNT_STEP: assert property (@(posedge core_clk_i) disable iff (rst_i)
      !$past(rst_i) && !$past(scan_tick_i) |-> accum == $past(accum) + ($past(edge_hit) ? 1 : 0)) // [R03]
      else $error("Count did not step by exactly one edge");

   AST_SCAN_CLEAR: assert property (@(posedge core_clk_i) disable iff (rst_i)
      scan_tick_i && !total_mode && !rst_i |=> accum == ($past(edge_hit) ? PEC_COUNT_ONE : PEC_COUNT_ZERO)) // [R09]
      else $error("Counter not cleared at scan");

   AST_SCAN_REPORT: assert property (@(posedge core_clk_i) disable iff (rst_i)
      scan_tick_i && !total_mode |=> edge_tally_instruction_o == $past(accum) && result_valid_o) // [R09]
      else $error("Scan snapshot wrong");

   AST_TOTAL_KEEP: assert property (@(posedge core_clk_i) disable iff (rst_i)
      scan_tick_i && total_mode && !$past(rst_i) |=> accum == $past(accum) + ($past(edge_hit) ? 1 : 0)) // [R01]
      else $error("Total cleared in count mode");

   // Checked against the pin history, not the synchroniser flops, so a broken chain is caught
   AST_EDGE_SENSE: assert property (@(posedge core_clk_i) disable iff (rst_i)
      edge_hit && !$past(rst_i) && !$past(rst_i, 2) && !$past(rst_i, 3)
      |-> $past(pulse_i, 2) == !stamp_mode && $past(pulse_i, 3) == stamp_mode) // [R02]
      else $error("Counted the wrong edge polarity");

   AST_STAMP_WITHIN: assert property (@(posedge core_clk_i) disable iff (rst_i)
      scan_tick_i && stamp_mode |=> stamp_within_o == $past(last_edge_stamp)) // [R10]
      else $error("Within-scan stamp wrong");

   AST_STAMP_BEFORE: assert property (@(posedge core_clk_i) disable iff (rst_i)
      scan_tick_i && stamp_mode |=> stamp_before_o == $past(prev_scan_stamp)) // [R10]
      else $error("Before-scan stamp wrong");

   AST_VALID_PULSE: assert property (@(posedge core_clk_i) disable iff (rst_i)
      result_valid_o |-> $past(scan_tick_i)) // [R09]
      else $error("Valid without a scan tick");

   AST_VALID_FOLLOWS: assert property (@(posedge core_clk_i) disable iff (rst_i)
      scan_tick_i |=> result_valid_o) // [R09]
      else $error("Scan tick gave no valid pulse");

   AST_OUT_HOLD: assert property (@(posedge core_clk_i) disable iff (rst_i)
      !scan_tick_i |=> $stable(edge_tally_instruction_o) && $stable(stamp_before_o) && $stable(stamp_within_o)) // [R09]
      else $error("Scan outputs moved between ticks");

   // In total mode an edge on the tick cycle must already be in the reported total
   AST_TOTAL_REPORT: assert property (@(posedge core_clk_i) disable iff (rst_i)
      scan_tick_i && total_mode |=> edge_tally_instruction_o == $past(accum) + ($past(edge_hit) ? 1 : 0)) // [R01]
      else $error("Raw total report wrong");

   AST_EDGE_CAPTURE: assert property (@(posedge core_clk_i) disable iff (rst_i)
      edge_hit |=> last_edge_stamp == $past(stamp_now)) // [R10]
      else $error("Edge time not captured");

   AST_EDGE_VARIANT_ZERO: assert property (@(posedge core_clk_i) disable iff (rst_i)
      result_valid_o && !stamp_mode |-> stamp_before_o == PEC_STAMP_ZERO && stamp_within_o == PEC_STAMP_ZERO) // [R10]
      else $error("Edge variant reported stamps");

   AST_RESET_CLEAR: assert property (@(posedge core_clk_i)
      rst_i |=> edge_tally_instruction_o == PEC_COUNT_ZERO && !result_valid_o && accum == PEC_COUNT_ZERO) // [R09]
      else $error("Reset left state behind");

endmodule : pec_counter

//--- bench/pec_host.sv
// Host model that polls the pulse edge counter once per scan
`timescale 1ns/100ps
module pec_host
(
   input wire logic core_clk_i,
   output logic scan_tick_o
);
   initial scan_tick_o = 1'b0;
   // Several ticks in a row read back-to-back intervals
   task automatic poll(int n);
      scan_tick_o = 1'b1;
      repeat (n) @(posedge core_clk_i);
      #1 scan_tick_o = 1'b0;
   endtask : poll
endmodule : pec_host

//--- bench/testbench.sv
// Self-checking bench for the pulse edge counter
`timescale 1ns/100ps
module testbench;
   import pec_pkg::*;
   logic core_clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic pulse_i = 1'b0;
   logic scan_tick_i;
   logic variant_i = 1'b0;
   logic [PEC_OPTION_W-1:0] averaging_option_i = PEC_OPTION_TOTAL;
   logic [PEC_COUNT_W-1:0] edge_tally_instruction_o;
   logic [PEC_STAMP_W-1:0] stamp_before_o;
   logic [PEC_STAMP_W-1:0] stamp_within_o;
   logic result_valid_o;
   logic [31:0] exp_q[$];
   logic exp_new_q[$];
   logic exp_new;
   logic [31:0] last_within = 32'h0;
   logic [31:0] seed = 32'hE655842E;
   logic [31:0] total = 32'h0;
   int err_count = 0;
   int comparisons = 0;
   int cycles = 0;
   always #2 core_clk_i = ~core_clk_i;
   pec_counter u_dut(.core_clk_i, .rst_i, .pulse_i, .scan_tick_i, .variant_i, .averaging_option_i,
      .edge_tally_instruction_o, .stamp_before_o, .stamp_within_o, .result_valid_o);
   pec_host u_host(.core_clk_i, .scan_tick_o(scan_tick_i));
   function automatic logic [31:0] xorshift(logic [31:0] s);
      s = s ^ (s << 13);
      s = s ^ (s >> 17);
      return s ^ (s << 5);
   endfunction : xorshift
   task automatic chk(string what, logic [31:0] got, logic [31:0] exp);
      comparisons++;
      if (got !== exp)
      begin
         err_count++;
         $display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
      end
   endtask : chk
   task automatic test_done();
      $display("comparisons %0d mismatches %0d", comparisons, err_count);
      if (err_count == 0 && comparisons > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask : test_done
   task automatic cyc(int n);
      repeat (n) @(posedge core_clk_i);
      #1;
   endtask : cyc
   // n whole pulses, then one lone edge whose polarity alternates
   task automatic scan(int n, int ticks);
      logic rise;
      logic [31:0] cnt;
      repeat (2 * n)
      begin
         pulse_i = ~pulse_i;
         cyc(2);
      end
      rise = ~pulse_i;
      pulse_i = ~pulse_i;
      cyc(5);
      cnt = 32'(n) + 32'(rise ^ variant_i);
      total += cnt;
      exp_q.push_back(averaging_option_i == PEC_OPTION_TOTAL ? total : cnt);
      repeat (ticks - 1) exp_q.push_back(averaging_option_i == PEC_OPTION_TOTAL ? total : 32'h0);
      exp_new_q.push_back(cnt != 32'h0);
      repeat (ticks - 1) exp_new_q.push_back(1'b0);
      u_host.poll(ticks);
      // Keeps the last edges of two scans more than one 40 ns tick apart
      cyc(11);
   endtask : scan
   // Results are taken mid-cycle, clear of the launching edge
   always @(negedge core_clk_i)
   begin
      cycles++;
      if (cycles > 20000)
      begin
         err_count++;
         test_done();
      end
      if (result_valid_o === 1'b1)
      begin
         exp_new = exp_new_q.size() > 0 ? exp_new_q.pop_front() : 1'b1;
         chk("tally", edge_tally_instruction_o, exp_q.size() > 0 ? exp_q.pop_front() : 32'hFFFFFFFF);
         chk("before", stamp_before_o, variant_i ? last_within : PEC_STAMP_ZERO);
         if (!variant_i)
            chk("within", stamp_within_o, PEC_STAMP_ZERO);
         else
         begin
            chk("new edge", 32'(stamp_within_o != last_within), 32'(exp_new));
            chk("period", 32'((stamp_within_o - stamp_before_o) != 32'h0), 32'(exp_new));
         end
         last_within = stamp_within_o;
      end
   end
   initial
   begin
      for (int t = 0; t < 4; t++)
      begin
         seed = xorshift(seed);
         variant_i = t[0];
         averaging_option_i = t[1] ? (seed[15:0] | 16'h0001) : PEC_OPTION_TOTAL;
         rst_i = 1'b1;
         pulse_i = 1'b0;
         total = 32'h0;
         last_within = 32'h0;
         cyc(4);
         rst_i = 1'b0;
         // Lets the timestamp leave zero before the first edge
         cyc(12);
         for (int s = 0; s < 6; s++)
         begin
            seed = xorshift(seed);
            scan(int'(seed[2:0]), s == 5 ? 2 : 1);
         end
         cyc(4);
         chk("unanswered", 32'(exp_q.size()), 32'h0);
         exp_new_q.delete();
         $display("test %0d done", t);
      end
      test_done();
   end
endmodule : testbench
